//--- rtl/host_bridge_config_header.v
// host bridge configuration header slice: status, class codes, latency
// timer and header type, plus the system error message request logic
// assumes a configuration access port already decoded to this function,
// with dword index, byte enables and single-cycle read/write strobes
//
// Functional notes
// - status bit 14 sets when a system error message is sent; write 1 clears
// - status bit 13 sets on master abort completion of own request; w1c
// - status bit 12 sets on target abort completion of own request; w1c
// - status bits 15, 11 and 8 always read 0, writes ignored
// - status bits 10:9 always read 00 (fast decode), writes ignored
// - status bit 7 always reads 1, writes ignored
// - status bit 4 always reads 1; capability pointer sits at offset 34h
// - status register resets to 0090h
// - stepping code at 08h is a fixed value, writes ignored
// - sub-class code at 0Ah reads 00h
// - base class code at 0Bh reads 06h
// - latency timer at 0Dh reads 0, writes ignored
// - header type at 0Eh has no storage, reads 0
// - message sending gated by device 0 enable ORed with device 1 enable
`timescale 1ns/1ps
`include "host_bridge_defines.vh"

module host_bridge_config_header
#(
    // arbitrary value, not any real part's stepping
    parameter [7:0] STEPPING_VAL = 8'h01
)
(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // configuration access port
    input  wire [5:0]  cfg_dw_addr,
    input  wire [3:0]  cfg_be,
    input  wire        cfg_rd,
    input  wire        cfg_wr,
    input  wire [31:0] cfg_wdata,
    output wire [31:0] cfg_rdata,
    output wire        cfg_ack,
    output wire        cfg_hit,
    // error message enables from the command registers
    input  wire        sys_error_msg_enable,
    input  wire        dev1_sys_error_msg_enable,
    // device 0 error condition, already qualified by its own enables
    input  wire        dev0_error_event,
    // system error message handshake toward the hub interface
    output wire        serr_msg_req,
    input  wire        serr_msg_ack,
    // completions returning for requests issued by the bridge
    input  wire        cpl_valid,
    input  wire        cpl_own,
    input  wire [1:0]  cpl_status,
    // flag view for other logic
    output wire [15:0] bridge_status
);

    // ****************************************************************
    // dword indices of the covered locations
    // ****************************************************************
    localparam [7:0] STATUS_OFS_W = `STATUS_OFS;
    localparam [7:0] STEP_OFS_W   = `STEPPING_OFS;
    localparam [7:0] LAT_OFS_W    = `LATENCY_OFS;
    localparam [5:0] DW_STATUS    = STATUS_OFS_W[7:2];
    localparam [5:0] DW_CLASS     = STEP_OFS_W[7:2];
    localparam [5:0] DW_MISC      = LAT_OFS_W[7:2];

    // ****************************************************************
    // message sender states
    // ****************************************************************
    localparam [1:0] MSG_IDLE = 2'h0;
    localparam [1:0] MSG_SEND = 2'h1;
    localparam [1:0] MSG_GAP  = 2'h2;

    reg  [1:0]  msg_state_q;
    reg  [1:0]  msg_state_d;
    reg         msg_pending_q;
    reg         msg_pending_d;
    reg         msg_sent;

    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         ack_q;

    wire        msg_gate;
    wire        new_error;
    wire        status_wr;
    wire        hi_lane_wr;
    wire [2:0]  flag_set;
    wire [2:0]  flag_clr;
    wire [2:0]  flags_q;
    wire [15:0] status_word;
    wire [31:0] class_word;
    wire [31:0] misc_word;

    // ****************************************************************
    // system error message gating
    // ****************************************************************
    // either function's enable lets the shared message out
    assign msg_gate  = sys_error_msg_enable | dev1_sys_error_msg_enable;
    assign new_error = dev0_error_event & msg_gate;

    // ****************************************************************
    // message sender
    // ****************************************************************
    // errors arriving while a message is outstanding are folded into
    // one follow-up message; the hub only needs to learn of an error once
    always @*
    begin
        msg_state_d   = msg_state_q;
        msg_pending_d = msg_pending_q;
        msg_sent      = 1'b0;
        case (msg_state_q)
            MSG_IDLE:
            begin
                if (new_error || msg_pending_q)
                begin
                    msg_state_d   = MSG_SEND;
                    msg_pending_d = 1'b0;
                end
            end
            MSG_SEND:
            begin
                if (new_error)
                    msg_pending_d = 1'b1;
                if (serr_msg_ack)
                begin
                    msg_sent    = 1'b1;
                    msg_state_d = MSG_GAP;
                end
            end
            MSG_GAP:
            begin
                // one idle cycle so the request drops between messages
                if (new_error)
                    msg_pending_d = 1'b1;
                msg_state_d = MSG_IDLE;
            end
            default:
            begin
                msg_state_d   = MSG_IDLE;
                msg_pending_d = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_state_q   <= MSG_IDLE;
            msg_pending_q <= 1'b0;
        end
        else
        begin
            msg_state_q   <= msg_state_d;
            msg_pending_q <= msg_pending_d;
        end
    end

    assign serr_msg_req = (msg_state_q == MSG_SEND);

    // ****************************************************************
    // sticky status flags
    // ****************************************************************
    assign status_wr  = cfg_wr & (cfg_dw_addr == DW_STATUS);
    assign hi_lane_wr = status_wr & cfg_be[3];

    // flag order: 2 = system error sent, 1 = master abort, 0 = target abort
    assign flag_set[2] = msg_sent;
    assign flag_set[1] = cpl_valid & cpl_own & (cpl_status == `CPL_MASTER_ABORT);
    assign flag_set[0] = cpl_valid & cpl_own & (cpl_status == `CPL_TARGET_ABORT);

    // status bit n sits at data bit 16+n; only a written 1 clears
    assign flag_clr[2] = hi_lane_wr & cfg_wdata[16 + `ST_SYS_ERR_BIT];
    assign flag_clr[1] = hi_lane_wr & cfg_wdata[16 + `ST_MASTER_ABORT_BIT];
    assign flag_clr[0] = hi_lane_wr & cfg_wdata[16 + `ST_TARGET_ABORT_BIT];

    sticky_flags
    #(
        .WIDTH   (3)
    )
    u_flags
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .set     (flag_set),
        .clr     (flag_clr),
        .flags_q (flags_q)
    );

    // ****************************************************************
    // status word assembly
    // ****************************************************************
    // flags reset to 0, so the word comes out of reset as the fixed 0090h
    assign status_word[`ST_PARITY_SEEN_BIT]  = 1'b0;
    assign status_word[`ST_SYS_ERR_BIT]      = flags_q[2];
    assign status_word[`ST_MASTER_ABORT_BIT] = flags_q[1];
    assign status_word[`ST_TARGET_ABORT_BIT] = flags_q[0];
    assign status_word[`ST_TA_SENT_BIT]      = 1'b0;
    assign status_word[`ST_DECODE_HI_BIT:`ST_DECODE_LO_BIT] = `DECODE_FAST;
    assign status_word[`ST_DATA_PARITY_BIT]  = 1'b0;
    assign status_word[`ST_B2B_BIT]          = 1'b1;
    assign status_word[6:5]                  = 2'h0;
    assign status_word[`ST_CAP_LIST_BIT]     = 1'b1;
    assign status_word[3:0]                  = 4'h0;

    assign bridge_status = status_word;

    // ****************************************************************
    // fixed identity and header words
    // ****************************************************************
    // byte 09h (programming interface) is outside this slice and reads 0
    assign class_word = {`BASE_CLASS_VAL, `SUB_CLASS_VAL, 8'h00, STEPPING_VAL};
    // 0Ch and 0Fh are outside this slice; 0Dh and 0Eh have no storage
    assign misc_word  = {8'h00, `HEADER_VAL, `LATENCY_VAL, 8'h00};

    // ****************************************************************
    // read path
    // ****************************************************************
    // the command register half of the status dword lives elsewhere and
    // returns 0 from here; the owner ORs its own lanes in
    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (cfg_dw_addr)
            DW_STATUS:
            begin
                if (cfg_be[2])
                    rdata_d[23:16] = status_word[7:0];
                if (cfg_be[3])
                    rdata_d[31:24] = status_word[15:8];
            end
            DW_CLASS:
            begin
                if (cfg_be[0])
                    rdata_d[7:0] = class_word[7:0];
                if (cfg_be[2])
                    rdata_d[23:16] = class_word[23:16];
                if (cfg_be[3])
                    rdata_d[31:24] = class_word[31:24];
            end
            DW_MISC:
            begin
                rdata_d = misc_word;
            end
            default:
            begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // access completion
    // ****************************************************************
    // writes to fixed fields are accepted and dropped, still acknowledged
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end
        else
        begin
            ack_q <= cfg_rd | cfg_wr;
            if (cfg_rd)
                rdata_q <= rdata_d;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_ack   = ack_q;
    assign cfg_hit   = (cfg_dw_addr == DW_STATUS) |
                       (cfg_dw_addr == DW_CLASS) |
                       (cfg_dw_addr == DW_MISC);

endmodule // host_bridge_config_header

//--- rtl/host_bridge_defines.vh
// constants for the host bridge configuration header slice
// assumes byte offsets in the function's 256-byte configuration space
`ifndef HOST_BRIDGE_DEFINES_VH
`define HOST_BRIDGE_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define STATUS_OFS          8'h06
`define STEPPING_OFS        8'h08
`define SUB_CLASS_OFS       8'h0a
`define BASE_CLASS_OFS      8'h0b
`define LATENCY_OFS         8'h0d
`define HEADER_OFS          8'h0e
`define CAP_PTR_OFS         8'h34

// ****************************************************************
// status field positions
// ****************************************************************
`define ST_PARITY_SEEN_BIT  15
`define ST_SYS_ERR_BIT      14
`define ST_MASTER_ABORT_BIT 13
`define ST_TARGET_ABORT_BIT 12
`define ST_TA_SENT_BIT      11
`define ST_DECODE_HI_BIT    10
`define ST_DECODE_LO_BIT    9
`define ST_DATA_PARITY_BIT  8
`define ST_B2B_BIT          7
`define ST_CAP_LIST_BIT     4

// ****************************************************************
// reset and fixed values
// ****************************************************************
`define STATUS_RESET        16'h0090
`define DECODE_FAST         2'h0
`define SUB_CLASS_VAL       8'h00
`define BASE_CLASS_VAL      8'h06
`define LATENCY_VAL         8'h00
`define HEADER_VAL          8'h00

// ****************************************************************
// hub completion status encodings and timing
// ****************************************************************
`define CPL_NORMAL          2'h0
`define CPL_MASTER_ABORT    2'h1
`define CPL_TARGET_ABORT    2'h2
`define CFG_ACK_CYCLES      1

`endif

//--- rtl/sticky_flags.v
// bank of hardware-set, write-one-to-clear flags
// assumes set and clear are single-cycle strobes on clk
`timescale 1ns/1ps

module sticky_flags
#(
    parameter WIDTH = 3
)
(
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // per-flag strobes
    input  wire [WIDTH-1:0] set,
    input  wire [WIDTH-1:0] clr,
    // flag state
    output wire [WIDTH-1:0] flags_q
);

    // ****************************************************************
    // one flop per flag
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_flag
            reg  flag_q;
            wire flag_d;

            // set wins over a clear in the same cycle so no event is lost
            assign flag_d = set[i] | (flag_q & ~clr[i]);

            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    flag_q <= 1'b0;
                else
                    flag_q <= flag_d;
            end

            assign flags_q[i] = flag_q;
        end
    endgenerate

endmodule // sticky_flags

//--- bench/host_bridge_config_header_assertions.sv
// checker for the host bridge configuration header slice
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/1ps

module hb_header_checker
#(
    parameter [7:0] STEPPING_VAL = 8'h01
)
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // configuration access port
    input wire logic [5:0]  cfg_dw_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_ack,
    input wire logic        cfg_hit,
    // message side
    input wire logic        sys_error_msg_enable,
    input wire logic        dev1_sys_error_msg_enable,
    input wire logic        dev0_error_event,
    input wire logic        serr_msg_req,
    input wire logic        serr_msg_ack,
    // completions and status
    input wire logic        cpl_valid,
    input wire logic        cpl_own,
    input wire logic [1:0]  cpl_status,
    input wire logic [15:0] bridge_status
);
    // ****************************************************************
    // helper: a qualified event is owed a message
    // ****************************************************************
    logic       armed_q;
    logic       req_q;
    wire        qual = dev0_error_event & (sys_error_msg_enable | dev1_sys_error_msg_enable);
    wire  [2:0] clr  = cfg_wdata[30:28] & {3{cfg_wr & cfg_be[3] & (cfg_dw_addr == 6'h01)}};

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            armed_q <= 1'b0;
            req_q   <= 1'b0;
        end
        else
        begin
            armed_q <= qual | (armed_q & ~(serr_msg_req & ~req_q));
            req_q   <= serr_msg_req;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // assertions
    // ****************************************************************
    chk_ack_pulse: assert property ((cfg_rd | cfg_wr) |=> cfg_ack)
        else $error("access not acknowledged");
    chk_fixed_bits: assert property ((bridge_status & 16'h8fff) == 16'h0090)
        else $error("fixed status bits wrong");
    chk_err_set: assert property (serr_msg_req && serr_msg_ack |=> bridge_status[14])
        else $error("sent error flag not set");
    chk_ma_set: assert property (cpl_valid && cpl_own && cpl_status == 2'h1 |=> bridge_status[13])
        else $error("master abort flag not set");
    chk_ta_set: assert property (cpl_valid && cpl_own && cpl_status == 2'h2 |=> bridge_status[12])
        else $error("target abort flag not set");
    chk_flag_sticky: assert property (($past(bridge_status[14:12]) & ~bridge_status[14:12] & ~$past(clr)) == 3'h0)
        else $error("flag cleared without write");
    chk_req_cause: assert property ($rose(serr_msg_req) |-> $past(armed_q | qual))
        else $error("message without enabled event");
    chk_req_holds: assert property (serr_msg_req && !serr_msg_ack |=> serr_msg_req)
        else $error("request dropped before ack");
    chk_req_gap: assert property (serr_msg_req && serr_msg_ack |=> !serr_msg_req [*2])
        else $error("request gap too short");
    chk_class_read: assert property (cfg_rd && cfg_dw_addr == 6'h02 && cfg_be == 4'hf |=> cfg_rdata == {24'h060000, STEPPING_VAL})
        else $error("class dword wrong");
    chk_dw3_zero: assert property (cfg_rd && cfg_dw_addr == 6'h03 |=> cfg_rdata == 32'h0)
        else $error("timer or header not zero");

    cover property (serr_msg_req && serr_msg_ack);
    cover property ($fell(bridge_status[13]));
    cover property (cfg_rd && cfg_dw_addr == 6'h02);
endmodule // hb_header_checker

bind host_bridge_config_header hb_header_checker #(.STEPPING_VAL(STEPPING_VAL)) hb_header_checker_i
(
    .clk(clk), .rst_n(rst_n), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .cfg_hit(cfg_hit), .sys_error_msg_enable(sys_error_msg_enable),
    .dev1_sys_error_msg_enable(dev1_sys_error_msg_enable), .dev0_error_event(dev0_error_event),
    .serr_msg_req(serr_msg_req), .serr_msg_ack(serr_msg_ack), .cpl_valid(cpl_valid),
    .cpl_own(cpl_own), .cpl_status(cpl_status), .bridge_status(bridge_status)
);

//--- bench/hub_model.sv
// far-side hub: accepts system error messages after a set wait
// assumes the request is a level held until one ack pulse
`timescale 1ns/1ps

module hub_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // message handshake
    input  wire logic       serr_msg_req,
    input  wire logic [3:0] ack_wait,
    output logic            serr_msg_ack
);
    logic [3:0] wait_q;

    // ack only after ack_wait cycles of request, then one clean pulse
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q       <= 4'h0;
            serr_msg_ack <= 1'b0;
        end
        else if (serr_msg_req && !serr_msg_ack && wait_q == ack_wait)
        begin
            wait_q       <= 4'h0;
            serr_msg_ack <= 1'b1;
        end
        else
        begin
            wait_q       <= (serr_msg_req && !serr_msg_ack) ? wait_q + 4'h1 : 4'h0;
            serr_msg_ack <= 1'b0;
        end
    end
endmodule // hub_model

//--- bench/host_bridge_config_header_bench.sv
// self-checking bench for the host bridge configuration header slice
// assumes the checker is bound from its own file and the hub model sits beside
`timescale 1ns/1ps

module host_bridge_config_header_bench;
    localparam [7:0] STEP = 8'h5a; // arbitrary stepping value
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  cfg_dw_addr = 6'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic        cfg_rd = 1'b0;
    logic        cfg_wr = 1'b0;
    logic [31:0] cfg_wdata = 32'h0;
    logic        en0 = 1'b0;
    logic        en1 = 1'b0;
    logic        ev = 1'b0;
    logic        cpl_valid = 1'b0;
    logic        cpl_own = 1'b0;
    logic [1:0]  cpl_status = 2'h0;
    logic [3:0]  ack_wait = 4'h0;
    wire  [31:0] cfg_rdata;
    wire         cfg_ack;
    wire         cfg_hit;
    wire         serr_msg_req;
    wire         serr_msg_ack;
    wire  [15:0] bridge_status;
    logic [32:0] exp_q[$];
    logic [15:0] st = 16'h0090;
    int          error_cnt = 0;
    int          samples_checked = 0;

    always #50 clk = ~clk;

    host_bridge_config_header #(.STEPPING_VAL(STEP)) host_bridge_config_header_i
    (
        .clk(clk), .rst_n(rst_n), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .cfg_hit(cfg_hit), .sys_error_msg_enable(en0), .dev1_sys_error_msg_enable(en1),
        .dev0_error_event(ev), .serr_msg_req(serr_msg_req), .serr_msg_ack(serr_msg_ack),
        .cpl_valid(cpl_valid), .cpl_own(cpl_own), .cpl_status(cpl_status),
        .bridge_status(bridge_status)
    );

    hub_model hub_model_i
    (
        .clk(clk), .rst_n(rst_n), .serr_msg_req(serr_msg_req), .ack_wait(ack_wait),
        .serr_msg_ack(serr_msg_ack)
    );

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // strobe stays up so back-to-back calls give back-to-back accesses
    task cyc(input bit rd, input [5:0] a, input [3:0] be, input [31:0] wd, input [31:0] exp);
        @(negedge clk);
        cfg_rd = rd;
        cfg_wr = !rd;
        cfg_dw_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        exp_q.push_back({rd, exp});
    endtask

    task idle;
        @(negedge clk);
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
    endtask

    task rd_st;
        cyc(1'b1, 6'h01, 4'hf, 32'h0, {st, 16'h0});
        check("status view", {16'h0, bridge_status}, {16'h0, st});
        idle();
    endtask

    task serr(input bit e0, input bit e1, input [3:0] w);
        @(negedge clk);
        ack_wait = w;
        en0 = e0;
        en1 = e1;
        ev = 1'b1;
        @(negedge clk);
        ev = 1'b0;
        for (int i = 0; i < 40 && bridge_status[14] !== 1'b1; i++)
            @(negedge clk);
        if (e0 | e1)
            st[14] = 1'b1;
        rd_st();
    endtask

    task cpl(input bit o, input [1:0] s);
        @(negedge clk);
        cpl_valid = 1'b1;
        cpl_own = o;
        cpl_status = s;
        @(negedge clk);
        cpl_valid = 1'b0;
    endtask

    // ****************************************************************
    // result watcher: every ack consumes the oldest note
    // ****************************************************************
    always @(negedge clk)
    begin
        if (cfg_ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected ack", 32'h1, 32'h0);
            else
            begin
                if (exp_q[0][32])
                    check("read data", cfg_rdata, exp_q[0][31:0]);
                void'(exp_q.pop_front());
            end
        end
    end

    initial
    begin
        #(100 * 6000);
        error_cnt++;
        results();
    end

    initial
    begin
        bit         o;
        logic [1:0] s;
        logic [2:0] c;
        void'($urandom(32'h4804));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd_st();
        cyc(1'b1, 6'h02, 4'hf, 32'h0, {24'h060000, STEP});
        #1 check("hit", {31'h0, cfg_hit}, 32'h1);
        cyc(1'b1, 6'h02, 4'h8, 32'h0, 32'h0600_0000);
        cyc(1'b1, 6'h03, 4'hf, 32'h0, 32'h0);
        cyc(1'b0, 6'h01, 4'hf, 32'hffff_ffff, 32'h0);
        cyc(1'b0, 6'h02, 4'hf, 32'hffff_ffff, 32'h0);
        cyc(1'b0, 6'h03, 4'hf, 32'hffff_ffff, 32'h0);
        cyc(1'b1, 6'h02, 4'h1, 32'h0, {24'h0, STEP});
        cyc(1'b1, 6'h03, 4'hf, 32'h0, 32'h0);
        cyc(1'b1, 6'h10, 4'hf, 32'h0, 32'h0);
        #1 check("hit", {31'h0, cfg_hit}, 32'h0);
        idle();
        rd_st();
        for (int i = 0; i < 12; i++)
        begin
            s = (i < 4) ? i[1:0] : 2'($urandom % 4);
            o = (i < 4) ? 1'b1 : 1'($urandom % 2);
            c = (i < 4) ? 3'h0 : 3'($urandom % 8);
            cpl(o, s);
            st[13] = st[13] | (o & s == 2'h1);
            st[12] = st[12] | (o & s == 2'h2);
            cyc(1'b0, 6'h01, 4'h8, {1'b0, c, 28'h0}, 32'h0);
            st[14:12] = st[14:12] & ~c;
            rd_st();
        end
        cyc(1'b0, 6'h01, 4'h8, 32'h3000_0000, 32'h0);
        idle();
        st[13:12] = 2'h0;
        serr(1'b0, 1'b0, 4'h0);
        serr(1'b1, 1'b0, 4'h7);
        cyc(1'b0, 6'h01, 4'h8, 32'h4000_0000, 32'h0);
        idle();
        st[14] = 1'b0;
        rd_st();
        serr(1'b0, 1'b1, 4'h0);
        // reset again with the sent-error flag standing
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        st = 16'h0090;
        rd_st();
        // let the watcher take the last ack of this edge first
        #1 check("pending notes", exp_q.size(), 32'h0);
        results();
    end
endmodule // host_bridge_config_header_bench
